// >>> rtl/hsem_regs.vh
`ifndef HSEM_REGS_VH
`define HSEM_REGS_VH

// ==========================================================
// Register offsets (byte addresses, low 8 address bits)
`define HSEM_OFS_DIODE_COND   8'h00
`define HSEM_OFS_DIODE_RISE   8'h04
`define HSEM_OFS_DIODE_FALL   8'h08
`define HSEM_OFS_DIODE_EVT    8'h0c
`define HSEM_OFS_DIODE_MASK   8'h10
`define HSEM_OFS_COOL_COND    8'h14
`define HSEM_OFS_COOL_RISE    8'h18
`define HSEM_OFS_COOL_FALL    8'h1c
`define HSEM_OFS_COOL_EVT     8'h20
`define HSEM_OFS_COOL_MASK    8'h24
`define HSEM_OFS_STD_EVT      8'h28
`define HSEM_OFS_STD_MASK     8'h2c
`define HSEM_OFS_STATUS_BYTE  8'h30
`define HSEM_OFS_SRQ_MASK     8'h34
`define HSEM_OFS_LAST_CMD_ERR 8'h38
`define HSEM_OFS_COMMAND      8'h3c

// ==========================================================
// Address and write-data fields
`define HSEM_ADDR_BITSEL      8
`define HSEM_ADDR_IDX_LO      9
`define HSEM_ADDR_IDX_HI      12
`define HSEM_WD_BITWR         31
`define HSEM_WD_IDX_LO        8
`define HSEM_WD_IDX_HI        11
`define HSEM_WD_VAL           0
`define HSEM_CMD_CLS          0

// ==========================================================
// Status byte layout
`define HSEM_SB_COOL          0
`define HSEM_SB_DIODE         1
`define HSEM_SB_IDLE          3
`define HSEM_SB_MAV           4
`define HSEM_SB_ESB           5
`define HSEM_SB_MSS           6

// ==========================================================
// Standard event bits and defined-bit mask
`define HSEM_STD_CME          5
`define HSEM_STD_DEFINED      8'h3d
`define HSEM_SRQ_WRITABLE     8'hbf

// ==========================================================
// Command error codes and reset values
`define HSEM_ERR_NONE         4'h0
`define HSEM_ERR_ILLEGAL_SET  4'h4
`define HSEM_ERR_BAD_HEX      4'hd
`define HSEM_ERR_UNKNOWN_TOK  4'he
`define HSEM_RST_ZERO16       16'h0000
`define HSEM_RST_ZERO8        8'h00

`endif

// >>> rtl/hsem_top.v
`timescale 1ns/1ps
`include "hsem_regs.vh"

// ==========================================================
// Sticky event latch, set wins over clear
module hsem_evt #(
  parameter W = 16
) (
  // Clock and reset
  input  wire         mclk,
  input  wire         resetn,
  // Set and clear vectors
  input  wire [W-1:0] set_v,
  input  wire [W-1:0] clr_v,
  // Latch contents
  output wire [W-1:0] q
);

  reg [W-1:0] lat_q;
  wire [W-1:0] lat_d;

  // Hold, clear on read, then set on top
  assign lat_d = (lat_q & ~clr_v) | set_v;

  // Latch register
  always @(posedge mclk) begin
    if (!resetn) begin
      lat_q <= {W{1'b0}};
    end else begin
      lat_q <= lat_d;
    end
  end

  assign q = lat_q;

endmodule

// ==========================================================
// Status model top
module hsem_top #(
  parameter DW = 16,
  parameter SW = 8
) (
  // Clock and reset
  input  wire          mclk,
  input  wire          resetn,
  // Register port
  input  wire [12:0]   addr,
  input  wire [31:0]   wdata,
  input  wire          wr,
  input  wire          rd,
  output wire [31:0]   rdata,
  // Live condition flags
  input  wire [DW-1:0] diode_cond,
  input  wire [DW-1:0] cooler_cond,
  // Standard event sources
  input  wire [SW-1:0] std_event_set,
  // Command parser error reports
  input  wire          set_on_query,
  input  wire          hex_block_bad,
  input  wire          token_unknown,
  input  wire          cmd_err_valid,
  input  wire [3:0]    cmd_err_code,
  // Interface condition bits
  input  wire          parser_idle,
  input  wire          msg_available,
  // Service request and status byte
  output wire          service_request,
  output wire [SW-1:0] status_byte
);

  // ========================================================
  // Declarations
  reg  [31:0]   rdata_q;
  reg  [DW-1:0] diode_cond_q;
  reg  [DW-1:0] cooler_cond_q;
  reg  [DW-1:0] diode_rise_select_q;
  reg  [DW-1:0] diode_fall_select_q;
  reg  [DW-1:0] diode_event_mask_q;
  reg  [DW-1:0] cooler_rise_select_q;
  reg  [DW-1:0] cooler_fall_select_q;
  reg  [DW-1:0] cooler_event_mask_q;
  reg  [SW-1:0] std_event_mask_q;
  reg  [SW-1:0] service_request_mask_q;
  reg  [3:0]    last_command_error_q;
  reg  [3:0]    last_command_error_d;
  reg           srq_q;
  reg  [SW-1:0] sb_q;
  reg  [15:0]   rd_val;
  reg  [DW-1:0] diode_clr;
  reg  [DW-1:0] cooler_clr;
  reg  [SW-1:0] std_clr;
  reg  [31:0]   rdata_d;

  wire [7:0]    ofs;
  wire          bit_rd;
  wire [3:0]    rd_idx;
  wire          bit_wr;
  wire [3:0]    wr_idx;
  wire          cls;
  wire          err_any;
  wire [DW-1:0] diode_rise;
  wire [DW-1:0] diode_fall;
  wire [DW-1:0] cooler_rise;
  wire [DW-1:0] cooler_fall;
  wire [DW-1:0] diode_event_latch;
  wire [DW-1:0] cooler_event_latch;
  wire [SW-1:0] standard_event_latch;
  wire [SW-1:0] std_set;
  wire [SW-1:0] sb_live;
  wire          master_summary_bit;
  wire [15:0]   std_mask_upd;
  wire [15:0]   srq_mask_upd;

  // ========================================================
  // Address and write-data fields
  assign ofs    = addr[7:0];
  assign bit_rd = addr[`HSEM_ADDR_BITSEL];
  assign rd_idx = addr[`HSEM_ADDR_IDX_HI:`HSEM_ADDR_IDX_LO];
  assign bit_wr = wdata[`HSEM_WD_BITWR];
  assign wr_idx = wdata[`HSEM_WD_IDX_HI:`HSEM_WD_IDX_LO];

  // Clear-status command strobe
  assign cls = wr && (ofs == `HSEM_OFS_COMMAND) && wdata[`HSEM_CMD_CLS];

  // Whole write, or one indexed bit set to a value
  function [15:0] upd;
    input [15:0] old;
    input        bw;
    input [3:0]  idx;
    input [15:0] wd;
    reg   [15:0] tmp;
    begin
      tmp = old;
      if (bw) begin
        tmp[idx] = wd[`HSEM_WD_VAL];
      end else begin
        tmp = wd;
      end
      upd = tmp;
    end
  endfunction
  // Byte masks after a write, bits above the byte dropped
  assign std_mask_upd = upd({8'h00, std_event_mask_q}, bit_wr, wr_idx, wdata[15:0]);
  assign srq_mask_upd = upd({8'h00, service_request_mask_q}, bit_wr, wr_idx, wdata[15:0]);

  // ========================================================
  // Condition sampling and edge selection
  always @(posedge mclk) begin
    if (!resetn) begin
      diode_cond_q  <= `HSEM_RST_ZERO16;
      cooler_cond_q <= `HSEM_RST_ZERO16;
    end else begin
      diode_cond_q  <= diode_cond;
      cooler_cond_q <= cooler_cond;
    end
  end

  // Rising and falling edges of each flag
  assign diode_rise  = diode_cond & ~diode_cond_q;
  assign diode_fall  = ~diode_cond & diode_cond_q;
  assign cooler_rise = cooler_cond & ~cooler_cond_q;
  assign cooler_fall = ~cooler_cond & cooler_cond_q;

  // ========================================================
  // Event latches
  hsem_evt #(
    .W (DW)
  ) u_diode_evt (
    .mclk   (mclk),
    .resetn (resetn),
    .set_v  ((diode_rise & diode_rise_select_q) | (diode_fall & diode_fall_select_q)),
    .clr_v  (diode_clr),
    .q      (diode_event_latch)
  );
  hsem_evt #(
    .W (DW)
  ) u_cooler_evt (
    .mclk   (mclk),
    .resetn (resetn),
    .set_v  ((cooler_rise & cooler_rise_select_q) | (cooler_fall & cooler_fall_select_q)),
    .clr_v  (cooler_clr),
    .q      (cooler_event_latch)
  );

  // Command errors also flag the standard latch
  assign err_any = set_on_query | hex_block_bad | token_unknown | cmd_err_valid;
  assign std_set = (std_event_set | ({{(SW-1){1'b0}}, err_any} << `HSEM_STD_CME)) & `HSEM_STD_DEFINED;

  hsem_evt #(
    .W (SW)
  ) u_std_evt (
    .mclk   (mclk),
    .resetn (resetn),
    .set_v  (std_set),
    .clr_v  (std_clr),
    .q      (standard_event_latch)
  );

  // Clear vectors from reads and clear-status
  always @* begin
    diode_clr  = {DW{1'b0}};
    cooler_clr = {DW{1'b0}};
    std_clr    = {SW{1'b0}};
    if (rd && (ofs == `HSEM_OFS_DIODE_EVT)) begin
      diode_clr = bit_rd ? ({{(DW-1){1'b0}}, 1'b1} << rd_idx) : {DW{1'b1}};
    end
    if (rd && (ofs == `HSEM_OFS_COOL_EVT)) begin
      cooler_clr = bit_rd ? ({{(DW-1){1'b0}}, 1'b1} << rd_idx) : {DW{1'b1}};
    end
    if (rd && (ofs == `HSEM_OFS_STD_EVT)) begin
      std_clr = bit_rd ? ({{(SW-1){1'b0}}, ~rd_idx[3]} << rd_idx[2:0]) : {SW{1'b1}};
    end
    if (cls) begin
      diode_clr  = {DW{1'b1}};
      cooler_clr = {DW{1'b1}};
      std_clr    = {SW{1'b1}};
    end
  end

  // ========================================================
  // Select and mask registers
  always @(posedge mclk) begin
    if (!resetn) begin
      diode_rise_select_q    <= `HSEM_RST_ZERO16;
      diode_fall_select_q    <= `HSEM_RST_ZERO16;
      diode_event_mask_q     <= `HSEM_RST_ZERO16;
      cooler_rise_select_q   <= `HSEM_RST_ZERO16;
      cooler_fall_select_q   <= `HSEM_RST_ZERO16;
      cooler_event_mask_q    <= `HSEM_RST_ZERO16;
      std_event_mask_q       <= `HSEM_RST_ZERO8;
      service_request_mask_q <= `HSEM_RST_ZERO8;
    end else if (wr) begin
      case (ofs)
        `HSEM_OFS_DIODE_RISE: begin
          diode_rise_select_q <= upd(diode_rise_select_q, bit_wr, wr_idx, wdata[15:0]);
        end
        `HSEM_OFS_DIODE_FALL: begin
          diode_fall_select_q <= upd(diode_fall_select_q, bit_wr, wr_idx, wdata[15:0]);
        end
        `HSEM_OFS_DIODE_MASK: begin
          diode_event_mask_q <= upd(diode_event_mask_q, bit_wr, wr_idx, wdata[15:0]);
        end
        `HSEM_OFS_COOL_RISE: begin
          cooler_rise_select_q <= upd(cooler_rise_select_q, bit_wr, wr_idx, wdata[15:0]);
        end
        `HSEM_OFS_COOL_FALL: begin
          cooler_fall_select_q <= upd(cooler_fall_select_q, bit_wr, wr_idx, wdata[15:0]);
        end
        `HSEM_OFS_COOL_MASK: begin
          cooler_event_mask_q <= upd(cooler_event_mask_q, bit_wr, wr_idx, wdata[15:0]);
        end
        `HSEM_OFS_STD_MASK: std_event_mask_q <= std_mask_upd[SW-1:0];
        `HSEM_OFS_SRQ_MASK: service_request_mask_q <= srq_mask_upd[SW-1:0] & `HSEM_SRQ_WRITABLE;
        default: ;
      endcase
    end
  end

  // ========================================================
  // Last command error, report wins over a clearing read
  always @* begin
    last_command_error_d = last_command_error_q;
    if (set_on_query) begin
      last_command_error_d = `HSEM_ERR_ILLEGAL_SET;
    end else if (hex_block_bad) begin
      last_command_error_d = `HSEM_ERR_BAD_HEX;
    end else if (token_unknown) begin
      last_command_error_d = `HSEM_ERR_UNKNOWN_TOK;
    end else if (cmd_err_valid) begin
      last_command_error_d = cmd_err_code;
    end else if (rd && (ofs == `HSEM_OFS_LAST_CMD_ERR)) begin
      last_command_error_d = `HSEM_ERR_NONE;
    end
  end
  always @(posedge mclk) begin
    if (!resetn) begin
      last_command_error_q <= `HSEM_ERR_NONE;
    end else begin
      last_command_error_q <= last_command_error_d;
    end
  end
  // ========================================================
  // Status byte and service request
  assign sb_live[`HSEM_SB_COOL]  = |(cooler_event_latch & cooler_event_mask_q);
  assign sb_live[`HSEM_SB_DIODE] = |(diode_event_latch & diode_event_mask_q);
  assign sb_live[2]              = 1'b0;
  assign sb_live[`HSEM_SB_IDLE]  = parser_idle;
  assign sb_live[`HSEM_SB_MAV]   = msg_available;
  assign sb_live[`HSEM_SB_ESB]   = |(standard_event_latch & std_event_mask_q);
  assign sb_live[`HSEM_SB_MSS]   = master_summary_bit;
  assign sb_live[7]              = 1'b0;

  // Mask bit 6 is held at zero, so no loop through the summary
  assign master_summary_bit = |(sb_live[5:0] & service_request_mask_q[5:0]) |
                              (sb_live[7] & service_request_mask_q[7]);
  // Registered status byte and request line
  always @(posedge mclk) begin
    if (!resetn) begin
      sb_q  <= `HSEM_RST_ZERO8;
      srq_q <= 1'b0;
    end else begin
      sb_q  <= sb_live;
      srq_q <= master_summary_bit;
    end
  end
  assign service_request = srq_q;
  assign status_byte     = sb_q;

  // ========================================================
  // Read multiplexer
  always @* begin
    case (ofs)
      `HSEM_OFS_DIODE_COND:   rd_val = diode_cond;
      `HSEM_OFS_DIODE_RISE:   rd_val = diode_rise_select_q;
      `HSEM_OFS_DIODE_FALL:   rd_val = diode_fall_select_q;
      `HSEM_OFS_DIODE_EVT:    rd_val = diode_event_latch;
      `HSEM_OFS_DIODE_MASK:   rd_val = diode_event_mask_q;
      `HSEM_OFS_COOL_COND:    rd_val = cooler_cond;
      `HSEM_OFS_COOL_RISE:    rd_val = cooler_rise_select_q;
      `HSEM_OFS_COOL_FALL:    rd_val = cooler_fall_select_q;
      `HSEM_OFS_COOL_EVT:     rd_val = cooler_event_latch;
      `HSEM_OFS_COOL_MASK:    rd_val = cooler_event_mask_q;
      `HSEM_OFS_STD_EVT:      rd_val = {8'h00, standard_event_latch};
      `HSEM_OFS_STD_MASK:     rd_val = {8'h00, std_event_mask_q};
      `HSEM_OFS_STATUS_BYTE:  rd_val = {8'h00, sb_live};
      `HSEM_OFS_SRQ_MASK:     rd_val = {8'h00, service_request_mask_q};
      `HSEM_OFS_LAST_CMD_ERR: rd_val = {12'h000, last_command_error_q};
      default:                rd_val = 16'h0000;
    endcase
  end
  // Whole value, or one bit in bit 0
  always @* begin
    rdata_d = 32'h0000_0000;
    rdata_d[15:0] = bit_rd ? {15'h0000, rd_val[rd_idx]} : rd_val;
  end
  // Read data valid only in the cycle after the strobe
  always @(posedge mclk) begin
    if (!resetn || !rd) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign rdata = rdata_q;

endmodule

// >>> verification/hsem_top_assertions.sv
`timescale 1ns/1ps
`include "hsem_regs.vh"
// ==========================================================
// Port checker for the status model
module hsem_top_assertions #(
  parameter DW = 16,
  parameter SW = 8
) (
  // Clock and reset
  input wire          mclk,
  input wire          resetn,
  // Register port
  input wire [12:0]   addr,
  input wire [31:0]   wdata,
  input wire          wr,
  input wire          rd,
  input wire [31:0]   rdata,
  // Flags and reports
  input wire [DW-1:0] diode_cond,
  input wire [DW-1:0] cooler_cond,
  input wire [SW-1:0] std_event_set,
  input wire          set_on_query,
  input wire          hex_block_bad,
  input wire          token_unknown,
  input wire          cmd_err_valid,
  input wire [3:0]    cmd_err_code,
  input wire          parser_idle,
  input wire          msg_available,
  // Status outputs
  input wire          service_request,
  input wire [SW-1:0] status_byte
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  reg cbit_q;
  // Selected cooler flag at each edge
  always @(posedge mclk) begin
    cbit_q <= cooler_cond[addr[12:9]];
  end
  sequence s_quiet;
    !(set_on_query || hex_block_bad || token_unknown || cmd_err_valid || rd);
  endsequence
  property p_srq_sb;
    service_request == status_byte[`HSEM_SB_MSS];
  endproperty
  property p_sb_undef;
    status_byte[2] == 1'b0 && status_byte[7] == 1'b0;
  endproperty
  property p_sb_iface;
    resetn |=> status_byte[3] == $past(parser_idle) && status_byte[4] == $past(msg_available);
  endproperty
  property p_cond_whole;
    rd && addr[8:0] == 9'h000 |=> rdata[DW-1:0] == $past(diode_cond);
  endproperty
  property p_cond_bit;
    rd && addr[8:0] == 9'h114 |=> rdata == {31'h0, cbit_q};
  endproperty
  property p_srq_bit6;
    rd && addr[7:0] == 8'h34 |=> rdata[6] == 1'b0;
  endproperty
  property p_err4;
    set_on_query ##1 s_quiet ##1 (rd && addr[7:0] == 8'h38) |=> rdata == 32'h4;
  endproperty
  property p_err13;
    hex_block_bad && !set_on_query ##1 s_quiet ##1 (rd && addr[7:0] == 8'h38) |=> rdata == 32'hd;
  endproperty
  a_srq_sb: assert property (p_srq_sb) else $error("service request differs from status bit 6");
  a_sb_undef: assert property (p_sb_undef) else $error("undefined status bit set");
  a_sb_iface: assert property (p_sb_iface) else $error("interface status bits wrong");
  a_cond_whole: assert property (p_cond_whole) else $error("diode condition read wrong");
  a_cond_bit: assert property (p_cond_bit) else $error("cooler condition bit read wrong");
  a_srq_bit6: assert property (p_srq_bit6) else $error("service mask bit 6 reads one");
  a_err4: assert property (p_err4) else $error("illegal set code wrong");
  a_err13: assert property (p_err13) else $error("bad hex code wrong");
  c_srq: cover property (service_request);
  c_evt_read: cover property (rd && addr[7:0] == 8'h0c);
  c_clear: cover property (wr && addr[7:0] == 8'h3c);
endmodule

bind hsem_top hsem_top_assertions #(.DW(DW), .SW(SW)) u_chk (
  .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .diode_cond(diode_cond), .cooler_cond(cooler_cond), .std_event_set(std_event_set),
  .set_on_query(set_on_query), .hex_block_bad(hex_block_bad), .token_unknown(token_unknown),
  .cmd_err_valid(cmd_err_valid), .cmd_err_code(cmd_err_code), .parser_idle(parser_idle),
  .msg_available(msg_available), .service_request(service_request), .status_byte(status_byte));

// >>> verification/hsem_src_model.sv
`timescale 1ns/1ps
// ==========================================================
// Far side: live flags and parser reports
module hsem_src_model (
  // Clock
  input wire        mclk,
  // Flags and reports
  output reg [15:0] diode_cond,
  output reg [15:0] cooler_cond,
  output reg [7:0]  std_event_set,
  output reg [3:0]  err_pulse,
  output reg [3:0]  cmd_err_code
);
  // Quiet levels at start
  initial begin
    diode_cond = 16'h0000;
    cooler_cond = 16'h0000;
    std_event_set = 8'h00;
    err_pulse = 4'h0;
    cmd_err_code = 4'h0;
  end
  // Flag change just after an edge
  task cond(input [15:0] d, input [15:0] c);
    begin
      @(posedge mclk);
      diode_cond <= d;
      cooler_cond <= c;
    end
  endtask
  // One-cycle report pulse
  task report(input [3:0] k, input [7:0] s, input [3:0] code);
    begin
      @(posedge mclk);
      err_pulse <= k;
      std_event_set <= s;
      cmd_err_code <= code;
      @(posedge mclk);
      err_pulse <= 4'h0;
      std_event_set <= 8'h00;
    end
  endtask
endmodule

// >>> verification/test_hierarchical_status_event_model.sv
`timescale 1ns/1ps
// ==========================================================
// Testbench
module test_hierarchical_status_event_model;
  reg         mclk;
  reg         resetn;
  reg  [12:0] addr;
  reg  [31:0] wdata;
  reg         wr;
  reg         rd;
  reg         parser_idle;
  reg         msg_available;
  wire [31:0] rdata;
  wire [15:0] diode_cond;
  wire [15:0] cooler_cond;
  wire [7:0]  std_event_set;
  wire [3:0]  err_pulse;
  wire [3:0]  cmd_err_code;
  wire        service_request;
  wire [7:0]  status_byte;
  reg  [15:0] codes = 16'h7ed4;
  integer     num_errors = 0;
  integer     total_checks = 0;
  integer     cycles = 0;
  integer     i;

  hsem_top DUT (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .diode_cond(diode_cond), .cooler_cond(cooler_cond), .std_event_set(std_event_set),
    .set_on_query(err_pulse[3]), .hex_block_bad(err_pulse[2]), .token_unknown(err_pulse[1]),
    .cmd_err_valid(err_pulse[0]), .cmd_err_code(cmd_err_code), .parser_idle(parser_idle),
    .msg_available(msg_available), .service_request(service_request), .status_byte(status_byte));

  hsem_src_model u_src (
    .mclk(mclk), .diode_cond(diode_cond), .cooler_cond(cooler_cond), .std_event_set(std_event_set),
    .err_pulse(err_pulse), .cmd_err_code(cmd_err_code));

  // ==========================================================
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors = num_errors + 1;
      results;
    end
  end

  // ==========================================================
  // Access tasks
  task check(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr_reg(input [12:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
    end
  endtask
  task rd_chk(input [12:0] a, input [31:0] exp);
    begin
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1 check(rdata, exp);
    end
  endtask
  task idle(input integer n);
    begin
      repeat (n) @(posedge mclk);
      #1;
    end
  endtask
  task results;
    begin
      if (num_errors == 0 && total_checks > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    addr = 13'h000;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    parser_idle = 1'b0;
    msg_available = 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    // Power-on values
    for (i = 0; i < 15; i = i + 1) begin
      rd_chk({i[10:0], 2'b00}, 32'h0);
    end
    // Whole and single-bit access
    wr_reg(13'h004, 32'h7fffffff);
    rd_chk(13'h004, 32'h0000ffff);
    wr_reg(13'h004, 32'h80000400);
    rd_chk(13'h004, 32'h0000ffef);
    rd_chk(13'h904, 32'h0);
    rd_chk(13'hb04, 32'h1);
    wr_reg(13'h034, 32'h000000ff);
    rd_chk(13'h034, 32'h000000bf);
    // Edge selection, sticky bits, exact clearing
    wr_reg(13'h004, 32'h1);
    wr_reg(13'h008, 32'h2);
    u_src.cond(16'h0003, 16'h0000);
    idle(3);
    rd_chk(13'h000, 32'h3);
    rd_chk(13'h000, 32'h3);
    rd_chk(13'h300, 32'h1);
    u_src.cond(16'h0000, 16'h0000);
    idle(3);
    rd_chk(13'h30c, 32'h1);
    rd_chk(13'h00c, 32'h1);
    rd_chk(13'h00c, 32'h0);
    // Summary and service request
    parser_idle <= 1'b1;
    wr_reg(13'h018, 32'hffff);
    wr_reg(13'h024, 32'h10);
    wr_reg(13'h034, 32'h1);
    u_src.cond(16'h0000, 16'h0010);
    idle(3);
    check({24'h0, status_byte}, 32'h49);
    check({31'h0, service_request}, 32'h1);
    rd_chk(13'h030, 32'h49);
    rd_chk(13'h114, 32'h0);
    rd_chk(13'h920, 32'h1);
    rd_chk(13'h020, 32'h0);
    idle(2);
    check({31'h0, service_request}, 32'h0);
    // Clear status
    u_src.cond(16'h0001, 16'h0011);
    u_src.report(4'h0, 8'h01, 4'h0);
    wr_reg(13'h03c, 32'h1);
    idle(1);
    rd_chk(13'h00c, 32'h0);
    rd_chk(13'h020, 32'h0);
    rd_chk(13'h028, 32'h0);
    // Command error codes, cleared on read
    for (i = 0; i < 4; i = i + 1) begin
      u_src.report(4'h8 >> i, 8'h00, 4'h7);
      rd_chk(13'h038, {28'h0, codes[4*i +: 4]});
      rd_chk(13'h038, 32'h0);
    end
    rd_chk(13'h028, 32'h20);
    results;
  end
endmodule
